// ### inc/sbc_cfg.svh
// Timing figures, pin patterns and reset values for the bank command issuer
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

// Clock period of core_clk_i in ns (20 MHz)
`define SBC_CLK_NS 50

// Number of banks and the bank-select width
`define SBC_BANKS 4
`define SBC_BANK_W 2

// Address bit that carries the auto precharge flag
`define SBC_AP_BIT 10

// Minimum times in ns, plain defaults
`define SBC_T_RCD_NS 20
`define SBC_T_RP_NS 20
`define SBC_T_RC_NS 65
`define SBC_T_RRD_NS 10
`define SBC_T_WR_NS 15
`define SBC_T_WTR_NS 10
`define SBC_T_MRD_NS 100
`define SBC_T_RFC_NS 75
`define SBC_T_XSNR_NS 200

// Least times round up to whole clocks
`define SBC_CEIL(ns) (((ns) + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_RCD_CYC `SBC_CEIL(`SBC_T_RCD_NS)
`define SBC_RP_CYC `SBC_CEIL(`SBC_T_RP_NS)
`define SBC_RC_CYC `SBC_CEIL(`SBC_T_RC_NS)
`define SBC_RRD_CYC `SBC_CEIL(`SBC_T_RRD_NS)
`define SBC_WR_CYC `SBC_CEIL(`SBC_T_WR_NS)
`define SBC_MRD_CYC `SBC_CEIL(`SBC_T_MRD_NS)
`define SBC_RFC_CYC `SBC_CEIL(`SBC_T_RFC_NS)
`define SBC_XSNR_CYC `SBC_CEIL(`SBC_T_XSNR_NS)
// Write-to-read delay in clocks: the lesser of 2 and the rounded ratio
`define SBC_WTR_CYC ((`SBC_CEIL(`SBC_T_WTR_NS) < 2) ? `SBC_CEIL(`SBC_T_WTR_NS) : 2)

// Extra clocks from a read to a write to another bank
`define SBC_RD2WR_EXTRA 2

// Row, column and write strobe patterns {ras_n, cas_n, we_n}
`define SBC_PAT_ACT 3'h3
`define SBC_PAT_READ 3'h5
`define SBC_PAT_WRITE 3'h4
`define SBC_PAT_PRE 3'h2
`define SBC_PAT_REF 3'h1
`define SBC_PAT_LOAD 3'h0
`define SBC_PAT_NOP 3'h7

// Reset values of the command pins
`define SBC_RST_CS_N 1'b1
`define SBC_RST_CKE 1'b0

`endif

// ### inc/sbc_pkg.sv
// Types shared by the bank command issuer
`default_nettype none

package sbc_pkg;

   // Operation requested on the user port
   typedef enum logic [2:0] {
      SBC_OP_ACT = 3'h0,
      SBC_OP_READ = 3'h1,
      SBC_OP_WRITE = 3'h2,
      SBC_OP_PRE = 3'h3,
      SBC_OP_REF = 3'h4,
      SBC_OP_LOAD = 3'h5
   } sbc_op_t;

   // Tracked state of one bank
   typedef enum logic [2:0] {
      SBC_BK_IDLE = 3'h0,
      SBC_BK_ACTIVATING = 3'h1,
      SBC_BK_ACTIVE = 3'h2,
      SBC_BK_READ = 3'h3,
      SBC_BK_WRITE = 3'h4,
      SBC_BK_READ_AP = 3'h5,
      SBC_BK_WRITE_AP = 3'h6,
      SBC_BK_PRECHARGING = 3'h7
   } sbc_bank_t;

   // Verdict on the pending request
   typedef enum logic [1:0] {
      SBC_DEC_WAIT = 2'h0,
      SBC_DEC_GO = 2'h1,
      SBC_DEC_ERR = 2'h2
   } sbc_dec_t;

endpackage

`default_nettype wire

// ### hdl/sbc_ctrl.sv
// Command issuer that drives a four-bank DDR2 memory over its command pins
//
// Notes on behaviour
// - Deselect or no-operation is always legal and lets work continue.
// - An idle bank places no limit on commands to other banks.
// - Busy bank n still allows activate, read, write, precharge elsewhere.
// - No write to any bank until a running read burst is done.
// - Read during another bank's write burst masks remaining write data.
// - Commands only with clock enable high twice and exit delay elapsed.
// - Other banks accept commands during auto precharge, without contention.
// - Write with auto precharge to read elsewhere: latency-1+half burst+wtr.
// - After auto precharge: half burst, half burst+2, or 1 clock spacing.
// - Write-to-read clocks are the lesser of 2 and the rounded ratio.
// - Refresh and mode register load only while all banks idle.
// - Never produce a bank state or command order outside the legal set.
// - After mode load only deselect until the mode set delay passes.
// - Activate opens row; bank needs precharge before another row opens.
// - Activates to one bank are spaced by the row cycle time.
// - Activates to different banks are spaced by the row-to-row delay.
// - Read or write waits row-to-column delay; times round up to clocks.
`timescale 1ns/10ps
`default_nettype none

`include "sbc_cfg.svh"

module sbc_ctrl
   import sbc_pkg::*;
#(
   parameter int READ_COLUMN_LATENCY = 3,
   parameter int BURST_LENGTH = 4,
   parameter int CW = 8,
   parameter int RW = 13
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   input wire sbc_op_t req_op_i,
   input wire logic [`SBC_BANK_W-1:0] req_bank_i,
   input wire logic [RW-1:0] req_addr_i,
   input wire logic req_ap_i,
   output logic req_ack_o,
   output logic req_err_o,
   output logic ready_o,
   output logic ddr_cke_o,
   output logic ddr_cs_n_o,
   output logic ddr_ras_n_o,
   output logic ddr_cas_n_o,
   output logic ddr_we_n_o,
   output logic [`SBC_BANK_W-1:0] ddr_ba_o,
   output logic [RW-1:0] ddr_addr_o,
   output logic data_mask_o
);

   // Clock counts at the working width
   localparam logic [CW-1:0] HALF_BURST_C = CW'(BURST_LENGTH / 2);
   localparam logic [CW-1:0] WL_C = CW'(READ_COLUMN_LATENCY - 1);
   localparam logic [CW-1:0] RCD_C = CW'(`SBC_RCD_CYC);
   localparam logic [CW-1:0] RP_C = CW'(`SBC_RP_CYC);
   localparam logic [CW-1:0] RC_C = CW'(`SBC_RC_CYC);
   localparam logic [CW-1:0] RRD_C = CW'(`SBC_RRD_CYC);
   localparam logic [CW-1:0] WR_C = CW'(`SBC_WR_CYC);
   localparam logic [CW-1:0] WTR_C = CW'(`SBC_WTR_CYC);
   localparam logic [CW-1:0] MRD_C = CW'(`SBC_MRD_CYC);
   localparam logic [CW-1:0] RFC_C = CW'(`SBC_RFC_CYC);
   localparam logic [CW-1:0] XSNR_C = CW'(`SBC_XSNR_CYC);
   localparam logic [CW-1:0] RD2WR_C = CW'(`SBC_RD2WR_EXTRA);
   localparam logic [CW-1:0] WBURST_C = WL_C + HALF_BURST_C;

   // Per-bank tracking
   sbc_bank_t bank_st [`SBC_BANKS];
   sbc_bank_t eff_st [`SBC_BANKS];
   logic [CW-1:0] bank_tmr [`SBC_BANKS];
   logic [CW-1:0] bank_rc [`SBC_BANKS];

   // Cross-bank spacing and link bring-up
   logic [CW-1:0] gap_rd;
   logic [CW-1:0] gap_wr;
   logic [CW-1:0] gap_rrd;
   logic [CW-1:0] quiet_cnt;
   logic [CW-1:0] wr_data_cnt;
   logic [CW-1:0] xs_cnt;
   logic cke_prev;
   logic all_idle;
   logic any_open;
   logic all_pre_ok;
   sbc_bank_t sel_st;
   sbc_dec_t dec;
   logic fire;
   logic issue;

   // Count down, holding at zero
   function automatic logic [CW-1:0] dec1(input logic [CW-1:0] v);
      return (v == '0) ? '0 : v - CW'(1);
   endfunction

   // Larger of two counts
   function automatic logic [CW-1:0] umax(input logic [CW-1:0] a,
                                          input logic [CW-1:0] b);
      return (a > b) ? a : b;
   endfunction

   // Length in clocks of each timed bank state
   function automatic logic [CW-1:0] dur(input sbc_bank_t s);
      unique case (s)
         SBC_BK_ACTIVATING: return RCD_C;
         SBC_BK_READ, SBC_BK_READ_AP: return HALF_BURST_C;
         SBC_BK_WRITE, SBC_BK_WRITE_AP: return WBURST_C + WR_C;
         SBC_BK_PRECHARGING: return RP_C;
         SBC_BK_IDLE, SBC_BK_ACTIVE: return '0;
      endcase
   endfunction

   // State a bank settles in when its timer runs out
   function automatic sbc_bank_t after(input sbc_bank_t s);
      unique case (s)
         SBC_BK_ACTIVATING: return SBC_BK_ACTIVE;
         SBC_BK_READ, SBC_BK_WRITE: return SBC_BK_ACTIVE;
         SBC_BK_READ_AP: return SBC_BK_PRECHARGING;
         SBC_BK_WRITE_AP: return SBC_BK_PRECHARGING;
         SBC_BK_PRECHARGING: return SBC_BK_IDLE;
         SBC_BK_IDLE, SBC_BK_ACTIVE: return s;
      endcase
   endfunction

   // Strobe pattern for each operation
   function automatic logic [2:0] pat(input sbc_op_t op);
      unique case (op)
         SBC_OP_ACT: return `SBC_PAT_ACT;
         SBC_OP_READ: return `SBC_PAT_READ;
         SBC_OP_WRITE: return `SBC_PAT_WRITE;
         SBC_OP_PRE: return `SBC_PAT_PRE;
         SBC_OP_REF: return `SBC_PAT_REF;
         SBC_OP_LOAD: return `SBC_PAT_LOAD;
         default: return `SBC_PAT_NOP;
      endcase
   endfunction

   // Bank state as seen this cycle, counting an expired timer as done
   always_comb begin
      for (int b = 0; b < `SBC_BANKS; b++) begin
         eff_st[b] = (bank_tmr[b] == '0) ? after(bank_st[b]) : bank_st[b];
      end
   end

   // Summary over all banks
   always_comb begin
      all_idle = 1'b1;
      any_open = 1'b0;
      all_pre_ok = 1'b1;
      for (int b = 0; b < `SBC_BANKS; b++) begin
         all_idle = all_idle & (eff_st[b] == SBC_BK_IDLE);
         any_open = any_open | (eff_st[b] == SBC_BK_ACTIVATING)
                    | (eff_st[b] == SBC_BK_ACTIVE)
                    | (eff_st[b] == SBC_BK_READ)
                    | (eff_st[b] == SBC_BK_WRITE);
         all_pre_ok = all_pre_ok & ((eff_st[b] == SBC_BK_IDLE)
                      | (eff_st[b] == SBC_BK_ACTIVE));
      end
   end

   // Verdict on the pending request: issue, wait, or refuse
   always_comb begin
      sel_st = eff_st[req_bank_i];
      dec = SBC_DEC_WAIT;
      if (!ready_o || quiet_cnt != '0) begin
         dec = SBC_DEC_WAIT;
      end else begin
         unique case (req_op_i)
            SBC_OP_ACT: begin
               if (sel_st == SBC_BK_IDLE) begin
                  dec = (bank_rc[req_bank_i] == '0 && gap_rrd == '0) ?
                        SBC_DEC_GO : SBC_DEC_WAIT;
               end else if (sel_st == SBC_BK_PRECHARGING
                            || sel_st == SBC_BK_READ_AP
                            || sel_st == SBC_BK_WRITE_AP) begin
                  dec = SBC_DEC_WAIT;
               end else begin
                  dec = SBC_DEC_ERR;
               end
            end
            SBC_OP_READ, SBC_OP_WRITE: begin
               if (sel_st == SBC_BK_ACTIVE) begin
                  if (req_op_i == SBC_OP_READ) begin
                     dec = (gap_rd == '0) ? SBC_DEC_GO : SBC_DEC_WAIT;
                  end else begin
                     dec = (gap_wr == '0) ? SBC_DEC_GO : SBC_DEC_WAIT;
                  end
               end else if (sel_st == SBC_BK_ACTIVATING
                            || sel_st == SBC_BK_READ
                            || sel_st == SBC_BK_WRITE) begin
                  dec = SBC_DEC_WAIT;
               end else begin
                  dec = SBC_DEC_ERR;
               end
            end
            SBC_OP_PRE: begin
               if (req_ap_i) begin
                  dec = all_pre_ok ? SBC_DEC_GO : SBC_DEC_WAIT;
               end else begin
                  dec = (sel_st == SBC_BK_IDLE || sel_st == SBC_BK_ACTIVE) ?
                        SBC_DEC_GO : SBC_DEC_WAIT;
               end
            end
            SBC_OP_REF, SBC_OP_LOAD: begin
               if (all_idle) begin
                  dec = SBC_DEC_GO;
               end else if (any_open) begin
                  dec = SBC_DEC_ERR;
               end else begin
                  dec = SBC_DEC_WAIT;
               end
            end
            default: dec = SBC_DEC_ERR;
         endcase
      end
   end

   // A request is answered once; the pulse cycle blocks a repeat
   assign fire = req_valid_i & ~req_ack_o & ~req_err_o;
   assign issue = fire & (dec == SBC_DEC_GO);

   // Clock enable bring-up and exit delay before the first command
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ddr_cke_o <= `SBC_RST_CKE;
         cke_prev <= `SBC_RST_CKE;
         xs_cnt <= XSNR_C;
         ready_o <= 1'b0;
      end else begin
         ddr_cke_o <= 1'b1;
         cke_prev <= ddr_cke_o;
         if (ddr_cke_o) begin
            xs_cnt <= dec1(xs_cnt);
         end
         ready_o <= ddr_cke_o & cke_prev & (xs_cnt == '0);
      end
   end

   // Command pins: a legal command for one cycle, otherwise deselect
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ddr_cs_n_o <= `SBC_RST_CS_N;
         {ddr_ras_n_o, ddr_cas_n_o, ddr_we_n_o} <= `SBC_PAT_NOP;
         ddr_ba_o <= '0;
         ddr_addr_o <= '0;
      end else if (issue) begin
         ddr_cs_n_o <= 1'b0;
         {ddr_ras_n_o, ddr_cas_n_o, ddr_we_n_o} <= pat(req_op_i);
         ddr_ba_o <= req_bank_i;
         unique case (req_op_i)
            SBC_OP_READ, SBC_OP_WRITE: begin
               ddr_addr_o <= req_addr_i;
               ddr_addr_o[`SBC_AP_BIT] <= req_ap_i;
            end
            SBC_OP_PRE: begin
               ddr_addr_o <= '0;
               ddr_addr_o[`SBC_AP_BIT] <= req_ap_i;
            end
            SBC_OP_REF: ddr_addr_o <= '0;
            default: ddr_addr_o <= req_addr_i;
         endcase
      end else begin
         ddr_cs_n_o <= 1'b1;
         {ddr_ras_n_o, ddr_cas_n_o, ddr_we_n_o} <= `SBC_PAT_NOP;
      end
   end

   // Request answers, one-cycle pulses
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         req_ack_o <= 1'b0;
         req_err_o <= 1'b0;
      end else begin
         req_ack_o <= issue;
         req_err_o <= fire & (dec == SBC_DEC_ERR);
      end
   end

   // Cross-bank spacing counters, loaded with the gap less one
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         gap_rd <= '0;
         gap_wr <= '0;
         gap_rrd <= '0;
         quiet_cnt <= '0;
      end else begin
         gap_rd <= dec1(gap_rd);
         gap_wr <= dec1(gap_wr);
         gap_rrd <= dec1(gap_rrd);
         quiet_cnt <= dec1(quiet_cnt);
         if (issue) begin
            unique case (req_op_i)
               SBC_OP_ACT: gap_rrd <= umax(dec1(gap_rrd), dec1(RRD_C));
               SBC_OP_READ: begin
                  gap_rd <= umax(dec1(gap_rd), dec1(HALF_BURST_C));
                  gap_wr <= umax(dec1(gap_wr),
                                 dec1(HALF_BURST_C + RD2WR_C));
               end
               SBC_OP_WRITE: begin
                  gap_wr <= umax(dec1(gap_wr), dec1(HALF_BURST_C));
                  if (req_ap_i) begin
                     gap_rd <= umax(dec1(gap_rd),
                                    dec1(WBURST_C + WTR_C));
                  end else begin
                     gap_rd <= umax(dec1(gap_rd), dec1(HALF_BURST_C));
                  end
               end
               SBC_OP_REF: quiet_cnt <= dec1(RFC_C);
               SBC_OP_LOAD: quiet_cnt <= dec1(MRD_C);
               default: quiet_cnt <= dec1(quiet_cnt);
            endcase
         end
      end
   end

   // Per-bank state and timers, advanced on every edge
   always_ff @(posedge core_clk_i) begin
      for (int b = 0; b < `SBC_BANKS; b++) begin
         if (reset_i) begin
            bank_st[b] <= SBC_BK_IDLE;
            bank_tmr[b] <= '0;
            bank_rc[b] <= '0;
         end else begin
            bank_rc[b] <= dec1(bank_rc[b]);
            if (issue && (`SBC_BANK_W'(b) == req_bank_i
                          || (req_op_i == SBC_OP_PRE && req_ap_i))) begin
               unique case (req_op_i)
                  SBC_OP_ACT: begin
                     bank_st[b] <= SBC_BK_ACTIVATING;
                     bank_tmr[b] <= dec1(RCD_C);
                     bank_rc[b] <= dec1(RC_C);
                  end
                  SBC_OP_READ: begin
                     bank_st[b] <= req_ap_i ? SBC_BK_READ_AP : SBC_BK_READ;
                     bank_tmr[b] <= dec1(HALF_BURST_C);
                  end
                  SBC_OP_WRITE: begin
                     bank_st[b] <= req_ap_i ? SBC_BK_WRITE_AP : SBC_BK_WRITE;
                     bank_tmr[b] <= dec1(WBURST_C + WR_C);
                  end
                  SBC_OP_PRE: begin
                     if (eff_st[b] == SBC_BK_ACTIVE) begin
                        bank_st[b] <= SBC_BK_PRECHARGING;
                        bank_tmr[b] <= dec1(RP_C);
                     end else begin
                        bank_st[b] <= eff_st[b];
                        bank_tmr[b] <= '0;
                     end
                  end
                  default: bank_tmr[b] <= dec1(bank_tmr[b]);
               endcase
            end else if (bank_st[b] != eff_st[b]) begin
               bank_st[b] <= eff_st[b];
               bank_tmr[b] <= dec1(dur(eff_st[b]));
            end else begin
               bank_tmr[b] <= dec1(bank_tmr[b]);
            end
         end
      end
   end

   // Mask the rest of a write burst when a read cuts in
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wr_data_cnt <= '0;
         data_mask_o <= 1'b0;
      end else begin
         if (issue && req_op_i == SBC_OP_WRITE) begin
            wr_data_cnt <= WBURST_C;
         end else begin
            wr_data_cnt <= dec1(wr_data_cnt);
         end
         if (issue && req_op_i == SBC_OP_READ && wr_data_cnt > CW'(1)) begin
            data_mask_o <= 1'b1;
         end else if (wr_data_cnt <= CW'(1)) begin
            data_mask_o <= 1'b0;
         end
      end
   end

endmodule // sbc_ctrl

`default_nettype wire

// ### bench/sbc_ctrl_monitor.sv
// Pin-level checker for the bank command issuer
`timescale 1ns/10ps
`default_nettype none
`include "sbc_cfg.svh"
module sbc_ctrl_monitor #(
   parameter int RW = 13
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic req_ack_o,
   input wire logic req_err_o,
   input wire logic ready_o,
   input wire logic ddr_cke_o,
   input wire logic ddr_cs_n_o,
   input wire logic ddr_ras_n_o,
   input wire logic ddr_cas_n_o,
   input wire logic ddr_we_n_o,
   input wire logic [RW-1:0] ddr_addr_o,
   input wire logic data_mask_o
);
   logic [2:0] pat;
   logic rd;
   logic wr;
   // Decode the command now on the pins
   assign pat = {ddr_ras_n_o, ddr_cas_n_o, ddr_we_n_o};
   assign rd = !ddr_cs_n_o && pat == `SBC_PAT_READ;
   assign wr = !ddr_cs_n_o && pat == `SBC_PAT_WRITE;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   one_cycle_cmd_a: assert property (!ddr_cs_n_o |=> ddr_cs_n_o)
      else $error("command held past one cycle");
   ack_on_pins_a: assert property (req_ack_o == !ddr_cs_n_o)
      else $error("ack and pins disagree");
   err_no_cmd_a: assert property (req_err_o |-> ddr_cs_n_o && !req_ack_o)
      else $error("refused request reached pins");
   deselect_idle_a: assert property (ddr_cs_n_o |-> pat == `SBC_PAT_NOP)
      else $error("strobes active while deselected");
   cke_before_cmd_a: assert property (!ddr_cs_n_o |->
      ddr_cke_o && $past(ddr_cke_o) && $past(ready_o))
      else $error("command without clock enable");
   rd_wr_gap_a: assert property (rd |=> (!wr) [*3])
      else $error("write too soon after read");
   wrap_rd_gap_a: assert property (wr && ddr_addr_o[`SBC_AP_BIT] |=>
      (!rd) [*4])
      else $error("read too soon after auto precharge write");
   mask_cause_a: assert property ($rose(data_mask_o) |-> rd)
      else $error("mask raised without a read");
   reset_pins_a: assert property (disable iff (1'b0) reset_i |=>
      ddr_cs_n_o && !ddr_cke_o && !req_ack_o && !ready_o)
      else $error("pins not quiet in reset");
   cover property (rd && ddr_addr_o[`SBC_AP_BIT]);
   cover property (wr && ddr_addr_o[`SBC_AP_BIT]);
   cover property ($rose(data_mask_o));
   cover property (req_err_o);
endmodule // sbc_ctrl_monitor
bind sbc_ctrl sbc_ctrl_monitor #(.RW(RW)) mon (.core_clk_i(core_clk_i),
   .reset_i(reset_i), .req_ack_o(req_ack_o), .req_err_o(req_err_o),
   .ready_o(ready_o), .ddr_cke_o(ddr_cke_o), .ddr_cs_n_o(ddr_cs_n_o),
   .ddr_ras_n_o(ddr_ras_n_o), .ddr_cas_n_o(ddr_cas_n_o),
   .ddr_we_n_o(ddr_we_n_o), .ddr_addr_o(ddr_addr_o),
   .data_mask_o(data_mask_o));
`default_nettype wire

// ### bench/sbc_mem_model.sv
// Behavioural memory device watching the command pins
`timescale 1ns/10ps
`default_nettype none
`include "sbc_cfg.svh"
module sbc_mem_model #(
   parameter int RW = 13
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ddr_cke_i,
   input wire logic ddr_cs_n_i,
   input wire logic ddr_ras_n_i,
   input wire logic ddr_cas_n_i,
   input wire logic ddr_we_n_i,
   input wire logic [1:0] ddr_ba_i,
   input wire logic [RW-1:0] ddr_addr_i,
   output logic [7:0] bad_o
);
   logic [RW-1:0] mode_reg [4];
   logic [RW-1:0] row [4];
   logic [3:0] open_bk;
   logic [RW-1:0] col;
   logic col_ap;
   logic cke_d;
   logic [2:0] pat;
   logic ap;
   assign pat = {ddr_ras_n_i, ddr_cas_n_i, ddr_we_n_i};
   assign ap = ddr_addr_i[`SBC_AP_BIT];
   // Clock enable of the previous edge
   always_ff @(posedge core_clk_i) begin
      cke_d <= reset_i ? 1'b0 : ddr_cke_i;
   end
   // Per-bank bookkeeping; commands without clock enable or against the open-bank state are counted
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         open_bk <= 4'h0;
         bad_o <= 8'h00;
      end else if (!ddr_cs_n_i) begin
         if (!(cke_d && ddr_cke_i) || (pat == `SBC_PAT_ACT &&
             open_bk[ddr_ba_i]) || ((pat == `SBC_PAT_READ ||
             pat == `SBC_PAT_WRITE) && !open_bk[ddr_ba_i]) ||
             ((pat == `SBC_PAT_REF || pat == `SBC_PAT_LOAD) &&
             |open_bk)) begin
            bad_o <= bad_o + 8'h01;
         end
         case (pat)
            `SBC_PAT_ACT: begin
               open_bk[ddr_ba_i] <= 1'b1;
               row[ddr_ba_i] <= ddr_addr_i;
            end
            `SBC_PAT_READ, `SBC_PAT_WRITE: begin
               col <= ddr_addr_i;
               col_ap <= ap;
               if (ap) begin
                  open_bk[ddr_ba_i] <= 1'b0;
               end
            end
            `SBC_PAT_PRE: begin
               if (ap) begin
                  open_bk <= 4'h0;
               end else begin
                  open_bk[ddr_ba_i] <= 1'b0;
               end
            end
            `SBC_PAT_LOAD: mode_reg[ddr_ba_i] <= ddr_addr_i;
            default: ;
         endcase
      end
   end
endmodule // sbc_mem_model
`default_nettype wire

// ### bench/sbc_ctrl_tb.sv
// Self-checking bench for the bank command issuer
`timescale 1ns/10ps
`default_nettype none
`include "sbc_cfg.svh"
module sbc_ctrl_tb;
   import sbc_pkg::*;
   localparam int RW = 13;
   localparam int READ_COLUMN_LATENCY = 3;
   localparam int BURST_LENGTH = 4;
   logic core_clk, reset, req_valid, req_ap, ack, err, ready, cke, mask;
   logic cs_n, ras_n, cas_n, we_n;
   sbc_op_t req_op;
   logic [1:0] req_bank, ba;
   logic [RW-1:0] req_addr, addr;
   logic [7:0] bad;
   int errors, num_checks, cyc, t1, t2;
   sbc_ctrl #(.READ_COLUMN_LATENCY(READ_COLUMN_LATENCY),
      .BURST_LENGTH(BURST_LENGTH), .CW(8), .RW(RW)) dut (.core_clk_i(core_clk),
      .reset_i(reset), .req_valid_i(req_valid), .req_op_i(req_op),
      .req_bank_i(req_bank), .req_addr_i(req_addr), .req_ap_i(req_ap),
      .req_ack_o(ack), .req_err_o(err), .ready_o(ready), .ddr_cke_o(cke),
      .ddr_cs_n_o(cs_n), .ddr_ras_n_o(ras_n), .ddr_cas_n_o(cas_n),
      .ddr_we_n_o(we_n), .ddr_ba_o(ba), .ddr_addr_o(addr),
      .data_mask_o(mask));
   sbc_mem_model #(.RW(RW)) mem (.core_clk_i(core_clk), .reset_i(reset),
      .ddr_cke_i(cke), .ddr_cs_n_i(cs_n), .ddr_ras_n_i(ras_n),
      .ddr_cas_n_i(cas_n), .ddr_we_n_i(we_n), .ddr_ba_i(ba),
      .ddr_addr_i(addr), .bad_o(bad));
   // Clock and edge counter
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   function automatic logic [2:0] pat_of(input sbc_op_t op);
      case (op)
         SBC_OP_ACT: return `SBC_PAT_ACT;
         SBC_OP_READ: return `SBC_PAT_READ;
         SBC_OP_WRITE: return `SBC_PAT_WRITE;
         SBC_OP_PRE: return `SBC_PAT_PRE;
         SBC_OP_REF: return `SBC_PAT_REF;
         default: return `SBC_PAT_LOAD;
      endcase
   endfunction
   // One request, held until answered; checks the answer and the pins
   task automatic issue(input sbc_op_t op, input logic [1:0] bk,
         input logic [RW-1:0] ad, input int ap, input int want_err);
      int n;
      @(negedge core_clk);
      req_op = op;
      req_bank = bk;
      req_addr = ad;
      req_ap = ap[0];
      req_valid = 1'b1;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 200);
      t1 = t2;
      t2 = cyc;
      req_valid = 1'b0;
      if (n >= 200) begin
         check("answer wait", 1, 0);
         print_verdict();
      end
      check("refused", want_err, err);
      if (want_err) begin
         check("pins on refusal", 1, cs_n);
      end else begin
         check("pins", {1'b0, pat_of(op)}, {cs_n, ras_n, cas_n, we_n});
         if (op != SBC_OP_REF && op != SBC_OP_PRE)
            check("bank", bk, ba);
         if (op == SBC_OP_READ || op == SBC_OP_WRITE)
            check("ap bit", ap, addr[`SBC_AP_BIT]);
      end
   endtask
   task automatic t_reset;
      int n;
      reset = 1'b1;
      repeat (5) @(negedge core_clk);
      check("cke in reset", 0, cke);
      check("cs in reset", 1, cs_n);
      reset = 1'b0;
      n = 0;
      while (ready !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      check("ready after reset", 1, ready);
      if (ready !== 1'b1) print_verdict();
   endtask
   task automatic t_load;
      for (int b = 0; b < 4; b++) begin
         issue(SBC_OP_LOAD, b[1:0], 13'(13'h0A50 + b), 0, 0);
         if (b > 0) check("load gap", 1, (t2 - t1) >= `SBC_MRD_CYC);
      end
      @(negedge core_clk);
      for (int b = 0; b < 4; b++) begin
         check("mode reg", 13'h0A50 + b, mem.mode_reg[b]);
      end
   endtask
   task automatic t_open_read;
      int t_act;
      issue(SBC_OP_ACT, 2'h0, 13'h1ABC, 0, 0);
      t_act = t2;
      issue(SBC_OP_READ, 2'h0, 13'h0105, 1, 0);
      @(negedge core_clk);
      check("open row", 13'h1ABC, mem.row[0]);
      check("column", 13'h0105, mem.col & 13'h0BFF);
      check("model ap", 1, mem.col_ap);
      issue(SBC_OP_READ, 2'h0, 13'h0000, 0, 1);
      issue(SBC_OP_ACT, 2'h0, 13'h1ABD, 0, 0);
      check("row cycle", 1, (t2 - t_act) >= `SBC_RC_CYC);
   endtask
   task automatic t_refused;
      issue(SBC_OP_READ, 2'h1, 13'h0000, 0, 1);
      issue(SBC_OP_ACT, 2'h1, 13'h0033, 0, 0);
      issue(SBC_OP_LOAD, 2'h0, 13'h0000, 0, 1);
      issue(SBC_OP_REF, 2'h0, 13'h0000, 0, 1);
      issue(sbc_op_t'(3'h6), 2'h0, 13'h0000, 0, 1);
   endtask
   task automatic t_gaps;
      issue(SBC_OP_ACT, 2'h2, 13'h0044, 0, 0);
      issue(SBC_OP_READ, 2'h1, 13'h0008, 0, 0);
      issue(SBC_OP_WRITE, 2'h2, 13'h0010, 1, 0);
      check("read to write gap", 1,
         (t2 - t1) >= BURST_LENGTH / 2 + 2);
      issue(SBC_OP_READ, 2'h1, 13'h0020, 0, 0);
      check("ap write to read", 1,
         (t2 - t1) >= (READ_COLUMN_LATENCY - 1) + BURST_LENGTH / 2
         + `SBC_WTR_CYC);
   endtask
   task automatic t_mask;
      int n;
      issue(SBC_OP_ACT, 2'h3, 13'h0077, 0, 0);
      issue(SBC_OP_WRITE, 2'h1, 13'h0030, 0, 0);
      issue(SBC_OP_READ, 2'h3, 13'h0040, 0, 0);
      n = 0;
      while (mask !== 1'b1 && n < 4) begin
         @(negedge core_clk);
         n++;
      end
      check("mask raised", 1, mask);
      n = 0;
      while (mask !== 1'b0 && n < 10) begin
         @(negedge core_clk);
         n++;
      end
      check("mask dropped", 0, mask);
      issue(SBC_OP_PRE, 2'h0, 13'h0000, 1, 0);
      @(negedge core_clk);
      check("all closed", 0, mem.open_bk);
      issue(SBC_OP_REF, 2'h0, 13'h0000, 0, 0);
   endtask
   // Main sequence
   initial begin
      {reset, req_valid, req_ap, req_bank, req_addr} = '0;
      req_op = SBC_OP_ACT;
      {errors, num_checks, t1, t2} = '0;
      t_reset();
      t_load();
      t_open_read();
      t_refused();
      t_gaps();
      t_mask();
      repeat (4) @(negedge core_clk);
      check("illegal commands", 0, bad);
      print_verdict();
   end
endmodule // sbc_ctrl_tb
`default_nettype wire
